/* verilog/scg_map.vh */
`ifndef SCG_MAP_VH
`define SCG_MAP_VH

// Register offsets
`define SCG_OFF_GATES 12'h118
`define SCG_OFF_STATUS 12'h200
`define SCG_OFF_CLEAR 12'h204
`define SCG_OFF_ENABLE 12'h208
`define SCG_OFF_ACTIVE 12'h20c

// Field positions
`define SCG_BIT_PHY 30
`define SCG_BIT_MAC 28
`define SCG_BIT_PORT_G 6
`define SCG_BIT_PORT_A 0

// Reset values and masks
`define SCG_GATES_RST 32'h0000_0000
`define SCG_GATES_MASK 32'h5000_007f
`define SCG_STATUS_RST 32'h0000_0000
`define SCG_ENABLE_RST 32'h0000_0000

// Unit count and address width
`define SCG_UNITS 9
`define SCG_AW 12

`endif

/* verilog/scg_gate_cell.v */
`timescale 1ns/1ps
`default_nettype none

module scg_gate_cell (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Gate request
    input wire gate_req_i,
    // Unit clock enable
    output reg clk_en_o,
    output reg active_o
);

    reg armed_r;

    // Enable only changes on a whole-cycle boundary
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_r <= 1'b0;
            active_o <= 1'b0;
            clk_en_o <= 1'b0;
        end else begin
            armed_r <= gate_req_i;
            active_o <= armed_r & gate_req_i; // RL11
            clk_en_o <= armed_r & gate_req_i; // RL4
        end
    end

endmodule // scg_gate_cell

`default_nettype wire

/* verilog/scg_top.v */
// Operation
// RL1: Bit 30 gates PHY unit clock
// RL2: Bit 28 gates MAC unit clock
// RL3: Bits 6..0 gate ports G..A
// RL4: Set runs unit, clear stops it
// RL5: Access to unclocked unit gives fault
// RL6: Reserved bits read zero, ignore writes
// RL7: Software preserves reserved bits on update
// RL8: Gate bits read/write, reset to zero
// RL9: Register applies only in sleep state
// RL10: Applies only with auto gating set
// RL11: Enable changes produce no clipped pulses
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.vh"

module scg_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register port
    input wire [`SCG_AW-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // Power state and outside gating
    input wire sleep_i,
    input wire deep_sleep_i,
    input wire auto_clock_gating_i,
    input wire [31:0] run_gates_i,
    input wire [31:0] deep_gates_i,
    // Unit accesses
    input wire [`SCG_UNITS-1:0] unit_access_i,
    // Unit clock enables
    output wire [`SCG_UNITS-1:0] unit_clk_en_o,
    // Fault and interrupt
    output reg bus_fault_o,
    output reg irq_o
);

    // Power states
    localparam [2:0] ST_RUN = 3'h1;
    localparam [2:0] ST_SLEEP = 3'h2;
    localparam [2:0] ST_DEEP = 3'h4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;

    reg [31:0] sleep_unit_clock_gates_r;
    reg [31:0] status_r;
    reg [31:0] status_nxt;
    reg [31:0] enable_r;
    reg [31:0] sel_gates;
    reg [31:0] fault_vec;
    reg [31:0] rdata_nxt;
    reg fault_nxt;

    wire [`SCG_UNITS-1:0] unit_req;
    wire [`SCG_UNITS-1:0] unit_active;
    reg [31:0] active_vec;

    wire wr_gates;
    wire wr_clear;
    wire wr_enable;

    // Gate words reduced to the documented positions
    wire [31:0] wdata_masked;
    wire [31:0] run_masked;
    wire [31:0] deep_masked;

    // Enable value seen by the interrupt this cycle
    wire [31:0] enable_eff;

    // Only implemented gate positions survive
    assign wdata_masked = wdata_i & `SCG_GATES_MASK; // RL6
    assign run_masked = run_gates_i & `SCG_GATES_MASK;
    assign deep_masked = deep_gates_i & `SCG_GATES_MASK;

    // Address decode
    assign wr_gates = wr_i && (addr_i == `SCG_OFF_GATES);
    assign wr_clear = wr_i && (addr_i == `SCG_OFF_CLEAR);
    assign wr_enable = wr_i && (addr_i == `SCG_OFF_ENABLE);

    // Power state tracking
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (deep_sleep_i) begin
                    state_nxt = ST_DEEP;
                end else if (sleep_i) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (deep_sleep_i) begin
                    state_nxt = ST_DEEP;
                end else if (!sleep_i) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DEEP: begin
                if (!deep_sleep_i) begin
                    state_nxt = sleep_i ? ST_SLEEP : ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Gating register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_unit_clock_gates_r <= `SCG_GATES_RST; // RL8
        end else if (wr_gates) begin
            sleep_unit_clock_gates_r <= wdata_i & `SCG_GATES_MASK; // RL6
        end
    end

    // Select which gating set drives the units
    always @* begin
        sel_gates = run_masked;
        if (auto_clock_gating_i) begin // RL10
            case (state_r)
                ST_RUN: begin
                    sel_gates = run_masked;
                end
                ST_SLEEP: begin
                    sel_gates = sleep_unit_clock_gates_r; // RL9
                end
                ST_DEEP: begin
                    sel_gates = deep_masked;
                end
                default: begin
                    sel_gates = run_masked;
                end
            endcase
        end
    end

    // Unit requests from the selected set
    assign unit_req[8] = sel_gates[`SCG_BIT_PHY]; // RL1
    assign unit_req[7] = sel_gates[`SCG_BIT_MAC]; // RL2
    assign unit_req[6:0] = sel_gates[`SCG_BIT_PORT_G:`SCG_BIT_PORT_A]; // RL3

    // One gate cell per unit
    genvar gi;
    generate
        for (gi = 0; gi < `SCG_UNITS; gi = gi + 1) begin : g_unit
            scg_gate_cell u_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .gate_req_i(unit_req[gi]),
                .clk_en_o(unit_clk_en_o[gi]),
                .active_o(unit_active[gi])
            );
        end
    endgenerate

    // Active units in register layout
    always @* begin
        active_vec = 32'h0000_0000;
        active_vec[`SCG_BIT_PHY] = unit_active[8];
        active_vec[`SCG_BIT_MAC] = unit_active[7];
        active_vec[`SCG_BIT_PORT_G:`SCG_BIT_PORT_A] = unit_active[6:0];
    end

    // Faults on accesses to unclocked units
    always @* begin
        fault_vec = 32'h0000_0000;
        fault_vec[`SCG_BIT_PHY] = unit_access_i[8] & ~unit_active[8];
        fault_vec[`SCG_BIT_MAC] = unit_access_i[7] & ~unit_active[7];
        fault_vec[`SCG_BIT_PORT_G:`SCG_BIT_PORT_A] = unit_access_i[6:0] & ~unit_active[6:0];
        fault_nxt = |fault_vec; // RL5
    end

    // Sticky status, set wins over clear
    always @* begin
        status_nxt = status_r;
        if (wr_clear) begin
            status_nxt = status_nxt & ~wdata_masked;
        end
        status_nxt = status_nxt | fault_vec;
    end

    // Sticky status register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_r <= `SCG_STATUS_RST;
        end else begin
            status_r <= status_nxt; // RL5
        end
    end

    // Interrupt enable register
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_r <= `SCG_ENABLE_RST;
        end else if (wr_enable) begin
            enable_r <= wdata_masked;
        end
    end

    // A fresh enable write already counts
    assign enable_eff = wr_enable ? wdata_masked : enable_r;

    // One-cycle fault pulse per faulting access
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_fault_o <= 1'b0;
        end else begin
            bus_fault_o <= fault_nxt; // RL5
        end
    end

    // Level interrupt from enabled status bits
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_nxt & enable_eff);
        end
    end

    // Read mux
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (addr_i)
            `SCG_OFF_GATES: begin
                rdata_nxt = sleep_unit_clock_gates_r & `SCG_GATES_MASK; // RL6
            end
            `SCG_OFF_STATUS: begin
                rdata_nxt = status_r;
            end
            `SCG_OFF_ENABLE: begin
                rdata_nxt = enable_r;
            end
            `SCG_OFF_ACTIVE: begin
                rdata_nxt = active_vec;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= rdata_nxt;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

endmodule // scg_top

`default_nettype wire

/* test/scg_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scg_map.vh"
module scg_props (
    // Clock, reset, bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Gating and faults
    input wire logic deep_sleep_i,
    input wire logic auto_clock_gating_i,
    input wire logic [31:0] run_gates_i,
    input wire logic [31:0] deep_gates_i,
    input wire logic [`SCG_UNITS-1:0] unit_access_i,
    input wire logic [`SCG_UNITS-1:0] unit_clk_en_o,
    input wire logic bus_fault_o
);
    wire f = |(unit_access_i & ~unit_clk_en_o);
    function automatic logic [8:0] m(input logic [31:0] g);
        m = {g[30], g[28], g[6:0]};
    endfunction
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    rd_rsvd_a: assert property ((rdata_o & ~`SCG_GATES_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    fault_cause_a: assert property (f |=> bus_fault_o)
        else $error("missing bus fault");
    fault_only_a: assert property (bus_fault_o |-> $past(f))
        else $error("spurious bus fault");
    run_sel_a: assert property ((!auto_clock_gating_i && $stable(run_gates_i))[*5] |-> unit_clk_en_o == m(run_gates_i))
        else $error("run gates not applied");
    deep_sel_a: assert property ((auto_clock_gating_i && deep_sleep_i && $stable(deep_gates_i))[*5]
        |-> unit_clk_en_o == m(deep_gates_i))
        else $error("deep gates not applied");
    rst_off_a: assert property ($past(rst_i) |-> unit_clk_en_o == 9'h0 && !bus_fault_o)
        else $error("units clocked after reset");
    short_pulse_a: assert property ((~$past(unit_clk_en_o, 2) & $past(unit_clk_en_o) & ~unit_clk_en_o) == 9'h0)
        else $error("one cycle clock enable pulse");
endmodule // scg_props
bind scg_top scg_props scg_props_inst (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .deep_sleep_i(deep_sleep_i), .auto_clock_gating_i(auto_clock_gating_i), .run_gates_i(run_gates_i),
    .deep_gates_i(deep_gates_i), .unit_access_i(unit_access_i), .unit_clk_en_o(unit_clk_en_o),
    .bus_fault_o(bus_fault_o));
`default_nettype wire

/* test/scg_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t got %h", $time, a); end end
module scg_top_tb;
    logic clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0;
    logic sleep_i = 1'h0, deep_sleep_i = 1'h0, auto_clock_gating_i = 1'h0;
    logic [11:0] addr_i = 12'h0;
    logic [31:0] wdata_i = 32'h0, run_gates_i = 32'h0, deep_gates_i = 32'h0, rv;
    logic [8:0] unit_access_i = 9'h0;
    wire [31:0] rdata_o;
    wire [8:0] unit_clk_en_o;
    wire bus_fault_o, irq_o;
    int mismatches = 0, checks = 0;
    always #12.5 clk_i = ~clk_i;
    scg_top scg_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
        .auto_clock_gating_i(auto_clock_gating_i), .run_gates_i(run_gates_i), .deep_gates_i(deep_gates_i),
        .unit_access_i(unit_access_i), .unit_clk_en_o(unit_clk_en_o), .bus_fault_o(bus_fault_o), .irq_o(irq_o));
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1;
        rv = rdata_o;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic hit(input logic [8:0] u);
        @(posedge clk_i);
        unit_access_i <= u;
        @(posedge clk_i);
        unit_access_i <= 9'h0;
        #1;
    endtask
    task automatic t_reset;
        `CHK(unit_clk_en_o, 9'h0)
        rd(12'h118);
        `CHK(rv, 32'h0)
        $display("reset test done");
    endtask
    task automatic t_regs;
        wr(12'h118, 32'hffffffff);
        rd(12'h118);
        `CHK(rv, 32'h5000007f)
        wr(12'h118, 32'h0);
        rd(12'h118);
        `CHK(rv, 32'h0)
        wr(12'h300, 32'hffffffff);
        rd(12'h300);
        `CHK(rv, 32'h0)
        wr(12'h118, 32'h40000000);
        rd(12'h118);
        wr(12'h118, rv | 32'h1);
        rd(12'h118);
        `CHK(rv, 32'h40000001)
        wr(12'h118, 32'h0);
        $display("register test done");
    endtask
    task automatic t_sleep;
        logic [31:0] g[3] = '{32'h40000001, 32'h10000040, 32'h0000003e};
        logic [8:0] e[3] = '{9'h101, 9'h0c0, 9'h03e};
        @(posedge clk_i);
        auto_clock_gating_i <= 1'h1;
        sleep_i <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            wr(12'h118, g[i]);
            cyc(4);
            `CHK(unit_clk_en_o, e[i])
            rd(12'h20c);
            `CHK(rv, g[i])
        end
        @(posedge clk_i);
        auto_clock_gating_i <= 1'h0;
        run_gates_i <= 32'h5;
        cyc(4);
        `CHK(unit_clk_en_o, 9'h005)
        @(posedge clk_i);
        auto_clock_gating_i <= 1'h1;
        deep_sleep_i <= 1'h1;
        deep_gates_i <= 32'h50000000;
        cyc(5);
        `CHK(unit_clk_en_o, 9'h180)
        @(posedge clk_i);
        deep_sleep_i <= 1'h0;
        sleep_i <= 1'h0;
        cyc(5);
        `CHK(unit_clk_en_o, 9'h005)
        @(posedge clk_i);
        auto_clock_gating_i <= 1'h0;
        run_gates_i <= 32'h7;
        @(posedge clk_i);
        run_gates_i <= 32'h5;
        repeat (4) begin
            cyc(1);
            `CHK(unit_clk_en_o[1], 1'h0)
        end
        $display("gating test done");
    endtask
    task automatic t_fault;
        wr(12'h208, 32'h10000000);
        hit(9'h080);
        `CHK(bus_fault_o, 1'h1)
        `CHK(irq_o, 1'h1)
        hit(9'h002);
        `CHK(bus_fault_o, 1'h1)
        rd(12'h200);
        `CHK(rv, 32'h10000002)
        wr(12'h204, 32'h10000000);
        cyc(1);
        `CHK(irq_o, 1'h0)
        wr(12'h208, 32'h2);
        cyc(1);
        `CHK(irq_o, 1'h1)
        wr(12'h204, 32'h2);
        cyc(1);
        `CHK(irq_o, 1'h0)
        hit(9'h001);
        `CHK(bus_fault_o, 1'h0)
        $display("fault test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset;
        t_regs;
        t_sleep;
        t_fault;
        print_verdict;
    end
    initial begin
        #50000;
        mismatches++;
        print_verdict;
    end
endmodule // scg_top_tb
`default_nettype wire
